// *** rtl/uda_pkg.sv ***
// Constants shared by the alarm interrupt block
package uda_pkg;
   // Register offsets are word indices; the byte address is four times the index
   localparam logic [7:0] IN_ALARM_STATUS_IDX = 8'hBC;
   localparam logic [7:0] OUT_ALARM_STATUS_IDX = 8'hBE;
   localparam logic [7:0] SIE_IRQ_ENABLE_IDX = 8'hC0;
   localparam logic [7:0] IN_ALARM_ENABLE_IDX = 8'hCC;
   localparam logic [7:0] OUT_ALARM_ENABLE_IDX = 8'hCE;
   localparam logic [7:0] EP_CONFIG_IDX = 8'hD0;
   localparam logic [7:0] EP_GROUP_STATUS_IDX = 8'hB4;
   localparam logic [7:0] EP_GROUP_ENABLE_IDX = 8'hC4;
   localparam logic [7:0] EP0_STATUS_IDX = 8'hB5;
   localparam logic [7:0] EP0_ENABLE_IDX = 8'hC5;
   localparam logic [7:0] SIE_STATUS_IDX = 8'hD4;
   localparam logic [7:0] DEVICE_IRQ_IDX = 8'hD8;
   localparam logic [15:0] ALARM_RESET = 16'h0000;
   localparam logic [15:0] ALARM_VALID = 16'hFFFE;
   localparam logic [7:0] SIE_ENABLE_RESET = 8'h00;
   localparam logic [7:0] SIE_ENABLE_VALID = 8'h7F;
   localparam int EP_COUNT = 16;
   localparam int GRP_ALARM_IN_BIT = 7;
   localparam int GRP_ALARM_OUT_BIT = 6;
   localparam int SIE_NON_IDLE_BIT = 6;
   localparam int EP0_OUT_ERR_BIT = 0;
   localparam int DEV_SIE_BIT = 0;
   localparam int DEV_EPGRP_BIT = 1;
   localparam int DEV_EP0_BIT = 2;
   typedef enum logic [1:0] {UDA_TOK_OUT, UDA_TOK_IN, UDA_TOK_PING, UDA_TOK_NONE} uda_tok_t;
   typedef enum logic [1:0] {UDA_RSP_PASS, UDA_RSP_NAK, UDA_RSP_ZLP, UDA_RSP_DROP} uda_rsp_t;
endpackage

// *** rtl/uda_w1c_reg.sv ***
// Sticky flag register with write-one-to-clear
`timescale 1ns/1ns
module uda_w1c_reg #(
   parameter int WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clear_bits,
   output logic [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_next;
   // A set in the same cycle as the clear wins, so no event is lost
   assign flags_next = (flags & ~clear_bits) | set_bits;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= flags_next;
      end
   end
endmodule // uda_w1c_reg

// *** rtl/uda_token_check.sv ***
// Classifies a token against endpoint state and picks the alarm response
`timescale 1ns/1ns
module uda_token_check (
   input wire logic [1:0] token_kind,
   input wire logic [3:0] token_ep,
   input wire logic high_speed,
   input wire logic [15:0] in_endpoint_enable_mask,
   input wire logic [15:0] out_endpoint_enable_mask,
   input wire logic [15:0] in_iso_response_select,
   input wire logic [15:0] out_iso_response_select,
   input wire logic [15:0] ep_ready_mask,
   output logic in_alarm,
   output logic out_alarm,
   output logic [1:0] response
);
   logic ep_ready;
   logic in_en;
   logic out_en;
   logic is_in;
   logic is_out;
   logic is_ping;
   assign is_in = token_kind == uda_pkg::UDA_TOK_IN;
   assign is_out = token_kind == uda_pkg::UDA_TOK_OUT;
   assign is_ping = token_kind == uda_pkg::UDA_TOK_PING;
   assign ep_ready = ep_ready_mask[token_ep];
   // Endpoint zero counts as enabled in both directions
   assign in_en = in_endpoint_enable_mask[token_ep] || token_ep == 4'h0;
   assign out_en = out_endpoint_enable_mask[token_ep] || token_ep == 4'h0;
   assign in_alarm = is_in && in_en && !ep_ready;
   assign out_alarm = is_out && out_en && !ep_ready;
   always_comb begin
      response = uda_pkg::UDA_RSP_PASS;
      if (in_alarm) begin
         response = in_iso_response_select[token_ep] ? uda_pkg::UDA_RSP_ZLP
                                                     : uda_pkg::UDA_RSP_NAK;
      end else if (out_alarm) begin
         response = out_iso_response_select[token_ep] ? uda_pkg::UDA_RSP_DROP
                                                      : uda_pkg::UDA_RSP_NAK;
      end else if (is_ping && high_speed && out_en && !ep_ready) begin
         response = uda_pkg::UDA_RSP_NAK;
      end
   end
endmodule // uda_token_check

// *** rtl/uda_alarm_irq.sv ***
// Alarm interrupt block of a USB device controller, with APB register access
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module uda_alarm_irq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic token_valid,
   input wire logic [1:0] token_kind,
   input wire logic [3:0] token_ep,
   input wire logic high_speed,
   input wire logic sleep_state,
   input wire logic [15:0] ep_attached_mask,
   input wire logic [15:0] in_endpoint_enable_mask,
   input wire logic [15:0] out_endpoint_enable_mask,
   input wire logic [15:0] in_iso_response_select,
   input wire logic [15:0] out_iso_response_select,
   input wire logic ep0_out_stall,
   input wire logic ep0_out_packet_error,
   input wire logic [6:0] sie_factors,
   output logic [1:0] alarm_response,
   output logic alarm_response_valid,
   output logic serial_engine_irq_summary,
   output logic irq
);
   logic [15:0] in_alarm_status_reg;
   logic [15:0] out_alarm_status_reg;
   logic [15:0] in_alarm_enable_reg;
   logic [15:0] out_alarm_enable_reg;
   logic [15:0] ep_config_reg;
   logic [7:0] sie_enable_reg;
   logic [7:0] ep_group_enable_reg;
   logic [7:0] ep0_status_reg;
   logic [7:0] ep0_enable_reg;
   logic [7:0] sie_enable_next;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_mux;
   logic [1:0] alarm_response_reg;
   logic alarm_response_valid_reg;
   logic in_alarm;
   logic out_alarm;
   logic [1:0] response;
   logic [15:0] ep_ready_mask;
   logic [15:0] in_set;
   logic [15:0] out_set;
   logic [15:0] in_clr;
   logic [15:0] out_clr;
   logic [7:0] ep0_set;
   logic [7:0] ep0_clr;
   logic [7:0] ep_group_status;
   logic [2:0] device_irq_summary_register;
   logic access;
   logic wr;
   logic rd_hit;
   logic unmapped;
   logic [9:0] word_idx;
   logic [15:0] wdata16;
   logic [7:0] wdata8;
   logic [15:0] ep_bit;

   function automatic logic hit(input logic [9:0] idx, input logic [7:0] reg_idx);
      hit = idx == {2'b00, reg_idx};
   endfunction

   // Bus decoding; APB answers in the access cycle with no wait states
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign word_idx = paddr[11:2];
   assign wdata16 = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wdata8 = pwdata[7:0] & {8{pstrb[0]}};
   assign rd_hit = hit(word_idx, uda_pkg::IN_ALARM_STATUS_IDX)
      || hit(word_idx, uda_pkg::OUT_ALARM_STATUS_IDX)
      || hit(word_idx, uda_pkg::SIE_IRQ_ENABLE_IDX)
      || hit(word_idx, uda_pkg::IN_ALARM_ENABLE_IDX)
      || hit(word_idx, uda_pkg::OUT_ALARM_ENABLE_IDX)
      || hit(word_idx, uda_pkg::EP_CONFIG_IDX)
      || hit(word_idx, uda_pkg::EP_GROUP_STATUS_IDX)
      || hit(word_idx, uda_pkg::EP_GROUP_ENABLE_IDX)
      || hit(word_idx, uda_pkg::EP0_STATUS_IDX)
      || hit(word_idx, uda_pkg::EP0_ENABLE_IDX)
      || hit(word_idx, uda_pkg::SIE_STATUS_IDX)
      || hit(word_idx, uda_pkg::DEVICE_IRQ_IDX);
   assign unmapped = access && !rd_hit;
   assign pready = 1'b1;
   assign pslverr = unmapped;
   assign prdata = prdata_reg;

   // Ready means configured by software and joined to a FIFO area; the pairing
   // stays in the FIFO logic, so this block only sees both as masks
   assign ep_ready_mask = ep_attached_mask & ep_config_reg;

   uda_token_check u_check (
      .token_kind(token_kind),
      .token_ep(token_ep),
      .high_speed(high_speed),
      .in_endpoint_enable_mask(in_endpoint_enable_mask),
      .out_endpoint_enable_mask(out_endpoint_enable_mask),
      .in_iso_response_select(in_iso_response_select),
      .out_iso_response_select(out_iso_response_select),
      .ep_ready_mask(ep_ready_mask),
      .in_alarm(in_alarm),
      .out_alarm(out_alarm),
      .response(response)
   );

   assign ep_bit = 16'h0001 << token_ep;
   // Bit 0 has no alarm flag, so endpoint zero alarms answer but do not latch
   assign in_set = (token_valid && in_alarm) ? (ep_bit & uda_pkg::ALARM_VALID)
                                             : 16'h0000;
   assign out_set = (token_valid && out_alarm) ? (ep_bit & uda_pkg::ALARM_VALID)
                                               : 16'h0000;
   assign in_clr = (wr && hit(word_idx, uda_pkg::IN_ALARM_STATUS_IDX)) ? wdata16
                                                                       : 16'h0000;
   assign out_clr = (wr && hit(word_idx, uda_pkg::OUT_ALARM_STATUS_IDX)) ? wdata16
                                                                         : 16'h0000;

   uda_w1c_reg #(.WIDTH(16)) u_in_status (
      .pclk(pclk),
      .presetn(presetn),
      .set_bits(in_set),
      .clear_bits(in_clr),
      .flags(in_alarm_status_reg)
   );

   uda_w1c_reg #(.WIDTH(16)) u_out_status (
      .pclk(pclk),
      .presetn(presetn),
      .set_bits(out_set),
      .clear_bits(out_clr),
      .flags(out_alarm_status_reg)
   );

   assign ep0_set = {7'h00, ep0_out_stall || ep0_out_packet_error};
   assign ep0_clr = (wr && hit(word_idx, uda_pkg::EP0_STATUS_IDX)) ? wdata8 : 8'h00;

   uda_w1c_reg #(.WIDTH(8)) u_ep0_status (
      .pclk(pclk),
      .presetn(presetn),
      .set_bits(ep0_set),
      .clear_bits(ep0_clr),
      .flags(ep0_status_reg)
   );

   // Summary bits are live combinations, never stored, so they follow clears at once
   assign ep_group_status = {
      |(in_alarm_status_reg & in_alarm_enable_reg),
      |(out_alarm_status_reg & out_alarm_enable_reg),
      6'h00
   };
   // Gating is pure logic with no clock gating, so the non-idle path survives sleep
   assign serial_engine_irq_summary = |({1'b0, sie_factors} & sie_enable_reg);
   assign device_irq_summary_register = {
      |(ep0_status_reg & ep0_enable_reg),
      |(ep_group_status & ep_group_enable_reg),
      serial_engine_irq_summary
   };
   assign irq = |device_irq_summary_register;

   assign sie_enable_next = wdata8 & uda_pkg::SIE_ENABLE_VALID;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sie_enable_reg <= uda_pkg::SIE_ENABLE_RESET;
      end else if (wr && hit(word_idx, uda_pkg::SIE_IRQ_ENABLE_IDX) && pstrb[0]) begin
         sie_enable_reg <= sie_enable_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_alarm_enable_reg <= uda_pkg::ALARM_RESET;
         out_alarm_enable_reg <= uda_pkg::ALARM_RESET;
         ep_config_reg <= uda_pkg::ALARM_RESET;
      end else if (wr) begin
         if (hit(word_idx, uda_pkg::IN_ALARM_ENABLE_IDX)) begin
            in_alarm_enable_reg <= wdata16 & uda_pkg::ALARM_VALID;
         end else if (hit(word_idx, uda_pkg::OUT_ALARM_ENABLE_IDX)) begin
            out_alarm_enable_reg <= wdata16 & uda_pkg::ALARM_VALID;
         end else if (hit(word_idx, uda_pkg::EP_CONFIG_IDX)) begin
            ep_config_reg <= wdata16;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ep_group_enable_reg <= 8'h00;
         ep0_enable_reg <= 8'h00;
      end else if (wr && pstrb[0]) begin
         if (hit(word_idx, uda_pkg::EP_GROUP_ENABLE_IDX)) begin
            ep_group_enable_reg <= pwdata[7:0] & 8'hC0;
         end else if (hit(word_idx, uda_pkg::EP0_ENABLE_IDX)) begin
            ep0_enable_reg <= pwdata[7:0];
         end
      end
   end

   always_comb begin
      rdata_mux = 32'h0000_0000;
      if (hit(word_idx, uda_pkg::IN_ALARM_STATUS_IDX)) begin
         rdata_mux = {16'h0000, in_alarm_status_reg};
      end else if (hit(word_idx, uda_pkg::OUT_ALARM_STATUS_IDX)) begin
         rdata_mux = {16'h0000, out_alarm_status_reg};
      end else if (hit(word_idx, uda_pkg::SIE_IRQ_ENABLE_IDX)) begin
         rdata_mux = {24'h000000, sie_enable_reg};
      end else if (hit(word_idx, uda_pkg::IN_ALARM_ENABLE_IDX)) begin
         rdata_mux = {16'h0000, in_alarm_enable_reg};
      end else if (hit(word_idx, uda_pkg::OUT_ALARM_ENABLE_IDX)) begin
         rdata_mux = {16'h0000, out_alarm_enable_reg};
      end else if (hit(word_idx, uda_pkg::EP_CONFIG_IDX)) begin
         rdata_mux = {16'h0000, ep_config_reg};
      end else if (hit(word_idx, uda_pkg::EP_GROUP_STATUS_IDX)) begin
         rdata_mux = {24'h000000, ep_group_status};
      end else if (hit(word_idx, uda_pkg::EP_GROUP_ENABLE_IDX)) begin
         rdata_mux = {24'h000000, ep_group_enable_reg};
      end else if (hit(word_idx, uda_pkg::EP0_STATUS_IDX)) begin
         rdata_mux = {24'h000000, ep0_status_reg};
      end else if (hit(word_idx, uda_pkg::EP0_ENABLE_IDX)) begin
         rdata_mux = {24'h000000, ep0_enable_reg};
      end else if (hit(word_idx, uda_pkg::SIE_STATUS_IDX)) begin
         rdata_mux = {25'h0, sie_factors};
      end else if (hit(word_idx, uda_pkg::DEVICE_IRQ_IDX)) begin
         rdata_mux = {29'h0, device_irq_summary_register};
      end
   end

   // Read data registered in the setup cycle so it is stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rdata_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_response_reg <= uda_pkg::UDA_RSP_PASS;
         alarm_response_valid_reg <= 1'b0;
      end else begin
         alarm_response_reg <= response;
         alarm_response_valid_reg <= token_valid;
      end
   end
   assign alarm_response = alarm_response_reg;
   assign alarm_response_valid = alarm_response_valid_reg;
endmodule // uda_alarm_irq

// *** tb/uda_alarm_assertions.sv ***
// Concurrent checks on the ports of the alarm interrupt block
`timescale 1ns/1ns
module uda_alarm_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic token_valid,
   input wire logic [1:0] token_kind,
   input wire logic [3:0] token_ep,
   input wire logic high_speed,
   input wire logic [15:0] ep_attached_mask,
   input wire logic [15:0] in_endpoint_enable_mask,
   input wire logic [15:0] out_endpoint_enable_mask,
   input wire logic [15:0] in_iso_response_select,
   input wire logic [15:0] out_iso_response_select,
   input wire logic [6:0] sie_factors,
   input wire logic [1:0] alarm_response,
   input wire logic alarm_response_valid,
   input wire logic serial_engine_irq_summary
);
   // Endpoint zero counts as enabled whatever its enable bit says
   wire logic ep0 = token_ep == 4'h0;
   wire logic free = !ep_attached_mask[token_ep];
   wire logic tok_in = token_valid && token_kind == uda_pkg::UDA_TOK_IN && free
      && (in_endpoint_enable_mask[token_ep] || ep0);
   wire logic out_on = free && (out_endpoint_enable_mask[token_ep] || ep0);
   wire logic tok_out = token_valid && token_kind == uda_pkg::UDA_TOK_OUT && out_on;
   wire logic tok_ping = token_valid && token_kind == uda_pkg::UDA_TOK_PING && out_on;
   wire logic [1:0] want_in = in_iso_response_select[token_ep] ? uda_pkg::UDA_RSP_ZLP
      : uda_pkg::UDA_RSP_NAK;
   wire logic [1:0] want_out = out_iso_response_select[token_ep] ? uda_pkg::UDA_RSP_DROP
      : uda_pkg::UDA_RSP_NAK;
   wire logic rd_setup = psel && !penable && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_in_alarm_reply: assert property (
      tok_in |=> alarm_response_valid && alarm_response == $past(want_in))
      else $error("alarmed IN token got a wrong reply");
   chk_out_alarm_reply: assert property (
      tok_out |=> alarm_response_valid && alarm_response == $past(want_out))
      else $error("alarmed OUT token got a wrong reply");
   chk_ping_nak: assert property (
      tok_ping && high_speed |=> alarm_response_valid && alarm_response == uda_pkg::UDA_RSP_NAK)
      else $error("PING to alarmed endpoint not refused");
   chk_reply_needs_token: assert property (
      !token_valid |=> !alarm_response_valid)
      else $error("reply without a token");
   chk_sie_gated: assert property (
      sie_factors == 7'h00 |-> !serial_engine_irq_summary)
      else $error("engine summary without any factor");
   chk_in_word_unused: assert property (
      rd_setup && paddr == 12'h2F0 |=> prdata[31:16] == 16'h0000 && !prdata[0])
      else $error("IN alarm word shows unused bits");
   chk_out_word_unused: assert property (
      rd_setup && paddr == 12'h2F8 |=> prdata[31:16] == 16'h0000 && !prdata[0])
      else $error("OUT alarm word shows unused bits");
   chk_sie_enable_width: assert property (
      rd_setup && paddr == 12'h300 |=> prdata[31:7] == 25'h0)
      else $error("engine enable shows bits above six");
   chk_zero_wait: assert property (
      psel && penable |-> pready)
      else $error("access phase stretched");
   chk_unmapped_error: assert property (
      psel && penable && paddr == 12'hFFC |-> pslverr)
      else $error("unmapped access not flagged");
endmodule // uda_alarm_assertions

// *** tb/uda_host_model.sv ***
// Host side token source facing the alarm block
`timescale 1ns/1ns
module uda_host_model (
   input wire logic pclk,
   input wire logic [1:0] alarm_response,
   input wire logic alarm_response_valid,
   output logic token_valid,
   output logic [1:0] token_kind,
   output logic [3:0] token_ep
);
   initial begin
      token_valid = 1'b0;
      token_kind = uda_pkg::UDA_TOK_NONE;
      token_ep = 4'hF;
   end
   // One token per call; the reply stands one cycle, so it is taken then
   task automatic send(input logic [1:0] kind, input logic [3:0] ep, output logic [2:0] rsp);
      @(posedge pclk);
      token_valid <= 1'b1;
      token_kind <= kind;
      token_ep <= ep;
      @(posedge pclk);
      token_valid <= 1'b0;
      token_kind <= uda_pkg::UDA_TOK_NONE;
      // Idle endpoint lines flip so a stale number is never mistaken for a token
      token_ep <= ~ep;
      #1;
      rsp = {alarm_response_valid, alarm_response};
   endtask
endmodule // uda_host_model

// *** tb/uda_alarm_irq_test.sv ***
// Self-checking bench for the alarm interrupt block
`timescale 1ns/1ns
module uda_alarm_irq_test;
   logic pclk, presetn, psel, penable, pwrite, high_speed, sleep_state, stall, perr;
   logic pready, pslverr, tv, rv, sum, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [15:0] att, in_en, out_en, in_iso, out_iso;
   logic [6:0] sie;
   logic [1:0] tk, rs;
   logic [3:0] te;
   int errors, tests_run;
   uda_alarm_irq uda_alarm_irq_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .token_valid(tv), .token_kind(tk),
      .token_ep(te), .high_speed, .sleep_state, .ep_attached_mask(att),
      .in_endpoint_enable_mask(in_en), .out_endpoint_enable_mask(out_en),
      .in_iso_response_select(in_iso), .out_iso_response_select(out_iso),
      .ep0_out_stall(stall), .ep0_out_packet_error(perr), .sie_factors(sie),
      .alarm_response(rs), .alarm_response_valid(rv), .serial_engine_irq_summary(sum), .irq);
   uda_host_model uda_host_model_inst (.pclk, .alarm_response(rs), .alarm_response_valid(rv),
      .token_valid(tv), .token_kind(tk), .token_ep(te));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         errors++;
         end_sim();
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(d, exp);
   endtask
   task automatic tok(input logic [1:0] k, input int ep, input logic on, input logic [1:0] x);
      logic [2:0] r;
      uda_host_model_inst.send(k, ep[3:0], r);
      check(32'(r), {29'h0, 1'b1, on ? x : 2'd0});
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Cuts a hang short without waiting on any one handshake
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      end_sim();
   end
   initial begin
      int ep;
      errors = 0;
      tests_run = 0;
      {presetn, psel, penable, pwrite, high_speed, sleep_state, stall, perr} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      att = 16'h0000;
      in_en = 16'hFFDE;
      out_en = 16'hFFF6;
      in_iso = 16'h00F0;
      out_iso = 16'h0F00;
      sie = 7'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h2F0, 32'h0);
      rd_chk(12'h2F8, 32'h0);
      rd_chk(12'h300, 32'h0);
      check(32'(irq), 32'h0);
      apb(1'b0, 12'hFFC, 32'h0);
      check({d[30:0], e}, 32'h1);
      apb(1'b1, 12'h300, 32'hFFFFFFFF);
      rd_chk(12'h300, 32'h7F);
      for (ep = 0; ep < 7; ep++) begin
         apb(1'b1, 12'h300, 32'h1 << ep);
         @(posedge pclk);
         sie <= 7'h7F ^ (7'h01 << ep);
         #1;
         check(32'(sum), 32'h0);
         @(posedge pclk);
         sie <= 7'h01 << ep;
         sleep_state <= ep == 6;
         #1;
         check(32'(sum), 32'h1);
      end
      sie <= 7'h00;
      for (ep = 0; ep < 16; ep++) begin
         tok(uda_pkg::UDA_TOK_IN, ep, in_en[ep] || ep == 0, in_iso[ep] ? 2'd2 : 2'd1);
         tok(uda_pkg::UDA_TOK_OUT, ep, out_en[ep] || ep == 0, out_iso[ep] ? 2'd3 : 2'd1);
      end
      rd_chk(12'h2F0, {16'h0, in_en & 16'hFFFE});
      rd_chk(12'h2F8, {16'h0, out_en & 16'hFFFE});
      apb(1'b1, 12'h2F0, 32'h000000AB);
      rd_chk(12'h2F0, {16'h0, in_en & ~16'h00AB & 16'hFFFE});
      apb(1'b1, 12'h2F8, 32'h0000FFFF);
      high_speed <= 1'b1;
      tok(uda_pkg::UDA_TOK_PING, 2, 1'b1, 2'd1);
      rd_chk(12'h2F8, 32'h0);
      in_en <= 16'hFFFF;
      att <= 16'h0020;
      apb(1'b1, 12'h340, 32'h20);
      apb(1'b1, 12'h2F0, 32'hFFFF);
      tok(uda_pkg::UDA_TOK_IN, 5, 1'b0, 2'd0);
      tok(uda_pkg::UDA_TOK_IN, 4, 1'b1, 2'd2);
      rd_chk(12'h2F0, 32'h10);
      apb(1'b1, 12'h310, 32'hC0);
      #1;
      check(32'(irq), 32'h0);
      apb(1'b1, 12'h330, 32'h10);
      #1;
      check(32'(irq), 32'h1);
      rd_chk(12'h2D0, 32'h80);
      apb(1'b1, 12'h2F0, 32'h10);
      #1;
      check(32'(irq), 32'h0);
      tok(uda_pkg::UDA_TOK_OUT, 2, 1'b1, 2'd1);
      apb(1'b1, 12'h338, 32'h4);
      rd_chk(12'h2D0, 32'h40);
      for (ep = 0; ep < 2; ep++) begin
         @(posedge pclk);
         stall <= ep == 0;
         perr <= ep == 1;
         @(posedge pclk);
         stall <= 1'b0;
         perr <= 1'b0;
         rd_chk(12'h2D4, 32'h1);
         apb(1'b1, 12'h2D4, 32'h1);
         rd_chk(12'h2D4, 32'h0);
      end
      end_sim();
   end
endmodule // uda_alarm_irq_test
bind uda_alarm_irq uda_alarm_assertions uda_alarm_assertions_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .token_valid, .token_kind, .token_ep,
   .high_speed, .ep_attached_mask, .in_endpoint_enable_mask, .out_endpoint_enable_mask,
   .in_iso_response_select, .out_iso_response_select, .sie_factors, .alarm_response,
   .alarm_response_valid, .serial_engine_irq_summary);
